// file: common/apd_pkg.sv
/*
  Package of the peripheral auto powerdown controller: register
  indices, field positions, reset values and timing counts.
  Assumes a 125 MHz APB clock and 32-bit word-aligned registers.
*/
package apd_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [3:0] IDX_STAT_A = 4'h0;
  localparam logic [3:0] IDX_STAT_B = 4'h1;
  localparam logic [3:0] IDX_DOC = 4'h2;
  localparam logic [3:0] IDX_MSR_RATE = 4'h4;
  localparam logic [3:0] IDX_FIFO = 4'h5;
  localparam logic [3:0] IDX_DIR_CCR = 4'h7;
  localparam logic [3:0] IDX_DIRECT = 4'h8;
  localparam logic [3:0] IDX_AUTO = 4'h9;
  localparam logic [3:0] IDX_PSTAT = 4'ha;
  localparam logic [3:0] IDX_PAR = 4'hb;
  // ==========================================================
  // Field positions
  localparam int AUTO_FDC = 0;
  localparam int AUTO_PAR = 3;
  localparam int AUTO_UART0 = 4;
  localparam int DOC_RST_N = 2;
  localparam int DOC_MOT_LO = 4;
  localparam int RATE_PD = 6;
  localparam int RATE_RST = 7;
  localparam int PAR_EPP = 0;
  localparam int PAR_ECP = 1;
  // ==========================================================
  // Reset values and constants
  localparam logic [7:0] DOC_RST = 8'h04;
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] PAR_RST = 8'h00;
  localparam logic [7:0] MSR_IDLE = 8'h80;
  // Extended control mode field codes
  localparam logic [2:0] ECR_SPP = 3'h0;
  localparam logic [2:0] ECR_BIDIR = 3'h1;
  localparam logic [2:0] ECR_EPP = 3'h4;
  // ==========================================================
  // Timing: idle interval before floppy auto powerdown
  localparam int CLK_MHZ = 125;
  localparam int IDLE_MS = 10;
  localparam int IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 21;
endpackage : apd_pkg

// file: design/apd_ctrl.sv
/*
  Power management control for the floppy controller, two serial
  ports and the parallel port, with an APB register slave.
  Assumes the floppy, serial and parallel cores run on pclk; only
  the serial receive and ring indicator pins are asynchronous.
*/
//
// Behaviour
// - Direct and automatic powerdown per floppy, serial and parallel
// - Floppy auto powerdown allowed only while auto bit 0 set
// - Floppy enters when motors off, status 80h, no int, timers done
// - Idle timer starts when auto powerdown is enabled
// - Clearing auto enable cancels timer and holds floppy awake
// - Rate-select powerdown overrides auto; auto resumes after wake
// - Hardware or software reset wakes with full reset sequence
// - Register-access wake keeps all state intact
// - Wake on motor bit write, status read, fifo read or write
// - After wake the 10 ms idle timer restarts
// - Other registers accessible in powerdown, data kept
// - Access in powerdown powers up only while it lasts
// - Bus, reset, clock and interrupt pins keep working
// - Motor, select, write pins tristated; step, head, density active
// - Serial auto enabled by bits 4,5; transmitter idles when empty
// - Receiver sleeps when fifo empty and waiting for start bit
// - Ring indicator change still flagged while port sleeps
// - Transmit write wakes transmitter; receive pin edge wakes receiver
// - Parallel auto bit 3; EPP sleeps if not enabled or selected
// - ECP sleeps if disabled or SPP, bidir or EPP mode chosen
// - Parallel state re-evaluated on mode or config change
`timescale 1ns/1ns
module apd_ctrl #(
  parameter int IDLE_CYCLES = apd_pkg::IDLE_CYC
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Floppy core status
  input wire logic [7:0] fdc_status_a,
  input wire logic [7:0] fdc_status_b,
  input wire logic [7:0] fdc_main_status,
  input wire logic [7:0] fdc_fifo_rdata,
  input wire logic [7:0] fdc_drive_input,
  input wire logic fdc_int,
  input wire logic head_unload_done,
  // Floppy core control
  output logic fdc_reset,
  output logic fdc_fifo_wr,
  output logic fdc_fifo_rd,
  output logic [7:0] fdc_fifo_wdata,
  output logic [7:0] fdc_rate_cfg,
  output logic fdc_active,
  // Floppy drive pins from the core
  input wire logic write_stream_core,
  input wire logic write_gate_core,
  input wire logic step_direction_core,
  input wire logic step_pulse_core,
  input wire logic head_select_core,
  input wire logic [1:0] density_select_core,
  // Floppy drive pins
  output logic [3:0] motor_on_out,
  output logic [3:0] motor_on_oe,
  output logic drive_select_out,
  output logic drive_select_oe,
  output logic write_stream_out,
  output logic write_stream_oe,
  output logic write_gate_out,
  output logic write_gate_oe,
  output logic step_direction_out,
  output logic step_pulse_out,
  output logic head_select_out,
  output logic [1:0] density_select_out,
  // Serial ports
  input wire logic [1:0] tx_holding_empty,
  input wire logic [1:0] tx_shift_empty,
  input wire logic [1:0] transmit_holding_wr,
  input wire logic [1:0] rx_fifo_empty,
  input wire logic [1:0] rx_wait_start,
  input wire logic [1:0] serial_receive_in,
  input wire logic [1:0] ring_indicator_in,
  output logic [1:0] tx_powered_down,
  output logic [1:0] rx_powered_down,
  output logic [1:0] ring_change,
  // Parallel port
  input wire logic [2:0] ecr_mode,
  output logic epp_powered_down,
  output logic ecp_powered_down,
  // Floppy power state
  output logic fdc_powered_down
);
  import apd_pkg::*;

  // ==========================================================
  // APB decode
  logic [3:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  assign idx = paddr[5:2];
  assign acc = psel && penable && pce;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  // Zero-wait slave; index 3, 6 and above 11 are unmapped
  always_comb begin
    case (idx)
      IDX_STAT_A, IDX_STAT_B, IDX_DOC, IDX_MSR_RATE,
      IDX_FIFO, IDX_DIR_CCR, IDX_DIRECT, IDX_AUTO,
      IDX_PSTAT, IDX_PAR: mapped = (paddr[1:0] == 2'b00);
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  logic wr_ok;
  logic rd_ok;
  assign wr_ok = wr && mapped;
  assign rd_ok = rd && mapped;

  // ==========================================================
  // Software registers
  logic [7:0] doc_ff;
  logic [7:0] ccr_ff;
  logic [7:0] direct_ff;
  logic [7:0] auto_ff;
  logic [7:0] par_ff;

  // Stored whatever the power state, so software sees its writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doc_ff <= DOC_RST;
      ccr_ff <= CCR_RST;
      direct_ff <= CFG_RST;
      auto_ff <= CFG_RST;
      par_ff <= PAR_RST;
    end else if (wr_ok) begin
      case (idx)
        IDX_DOC: doc_ff <= pwdata[7:0];
        IDX_DIR_CCR: ccr_ff <= pwdata[7:0];
        IDX_DIRECT: direct_ff <= pwdata[7:0];
        IDX_AUTO: auto_ff <= pwdata[7:0];
        IDX_PAR: par_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Floppy wake and reset events
  logic doc_wr;
  logic rate_wr;
  logic motor_wake;
  logic acc_wake;
  logic sw_reset;
  logic auto_en;
  assign doc_wr = wr_ok && idx == IDX_DOC;
  assign rate_wr = wr_ok && idx == IDX_MSR_RATE;
  // Reading the drive output register is not a wake event
  assign motor_wake = doc_wr && |pwdata[7:DOC_MOT_LO];
  assign acc_wake = motor_wake
    || (rd_ok && idx == IDX_MSR_RATE)
    || (acc && mapped && idx == IDX_FIFO);
  assign sw_reset = (doc_wr && !pwdata[DOC_RST_N])
    || (rate_wr && pwdata[RATE_RST]);
  assign auto_en = auto_ff[AUTO_FDC];

  // Reset pulse to the core runs its normal reset sequence
  logic fdc_reset_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fdc_reset_ff <= 1'b1;
    end else if (pce) begin
      fdc_reset_ff <= sw_reset;
    end
  end
  assign fdc_reset = fdc_reset_ff;

  // ==========================================================
  // Rate-select powerdown, ended by any reset
  logic rate_pd_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_pd_ff <= 1'b0;
    end else if (pce) begin
      if (sw_reset) begin
        rate_pd_ff <= 1'b0;
      end else if (rate_wr && pwdata[RATE_PD]) begin
        rate_pd_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Idle interval timer
  logic auto_en_d_ff;
  logic tmr_restart;
  logic tmr_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_en_d_ff <= 1'b0;
    end else if (pce) begin
      auto_en_d_ff <= auto_en;
    end
  end
  // Restart on enable, on any wake and on reset
  assign tmr_restart = (auto_en && !auto_en_d_ff)
    || acc_wake || sw_reset;

  apd_idle_timer #(
    .TERM(IDLE_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .run(auto_en),
    .restart(tmr_restart),
    .expired(tmr_done)
  );

  // ==========================================================
  // Floppy auto powerdown state
  logic fdc_idle;
  logic auto_pd_ff;
  assign fdc_idle = ~|doc_ff[7:DOC_MOT_LO]
    && fdc_main_status == MSR_IDLE
    && !fdc_int && head_unload_done && tmr_done;

  // Wake events override entry in the same cycle, so no access
  // that should wake the part is lost to a simultaneous entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_pd_ff <= 1'b0;
    end else if (pce) begin
      if (!auto_en) begin
        auto_pd_ff <= 1'b0;
      end else if (acc_wake || sw_reset) begin
        auto_pd_ff <= 1'b0;
      end else if (fdc_idle) begin
        auto_pd_ff <= 1'b1;
      end
    end
  end

  logic fdc_pd;
  // Rate-select and direct powerdown win over the auto state
  assign fdc_pd = rate_pd_ff || direct_ff[AUTO_FDC]
    || auto_pd_ff;
  assign fdc_powered_down = fdc_pd;
  // Core wakes only for the duration of an access in powerdown
  assign fdc_active = !fdc_pd || (psel && idx <= IDX_DIR_CCR);

  // ==========================================================
  // Floppy core data path; core state is never cleared by sleep
  assign fdc_fifo_wr = wr_ok && idx == IDX_FIFO;
  assign fdc_fifo_rd = rd_ok && idx == IDX_FIFO;
  assign fdc_fifo_wdata = pwdata[7:0];
  assign fdc_rate_cfg = ccr_ff;

  // ==========================================================
  // Drive pins: disconnect ones that can draw drive current
  assign motor_on_out = ~doc_ff[7:DOC_MOT_LO];
  assign motor_on_oe = {4{!fdc_pd}};
  assign drive_select_out = !doc_ff[0];
  assign drive_select_oe = !fdc_pd;
  assign write_stream_out = write_stream_core;
  assign write_stream_oe = !fdc_pd;
  assign write_gate_out = write_gate_core;
  assign write_gate_oe = !fdc_pd;
  // Positioning pins keep driving in powerdown
  assign step_direction_out = step_direction_core;
  assign step_pulse_out = step_pulse_core;
  assign head_select_out = head_select_core;
  assign density_select_out = density_select_core;

  // ==========================================================
  // Serial ports, one copy per port
  logic [1:0] rxd_s1_ff;
  logic [1:0] rxd_s2_ff;
  logic [1:0] rxd_d_ff;
  logic [1:0] ri_s1_ff;
  logic [1:0] ri_s2_ff;
  logic [1:0] ri_d_ff;
  logic [1:0] tx_pd_ff;
  logic [1:0] rx_pd_ff;
  logic [1:0] ri_chg_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_uart
      logic en;
      assign en = auto_ff[AUTO_UART0 + g] || direct_ff[AUTO_UART0 + g];

      // Pin synchronisers; stage two and the history flop are
      // the only inputs of the edge detect
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rxd_s1_ff[g] <= 1'b1;
          rxd_s2_ff[g] <= 1'b1;
          rxd_d_ff[g] <= 1'b1;
          ri_s1_ff[g] <= 1'b0;
          ri_s2_ff[g] <= 1'b0;
          ri_d_ff[g] <= 1'b0;
        end else if (pce) begin
          rxd_s1_ff[g] <= serial_receive_in[g];
          rxd_s2_ff[g] <= rxd_s1_ff[g];
          rxd_d_ff[g] <= rxd_s2_ff[g];
          ri_s1_ff[g] <= ring_indicator_in[g];
          ri_s2_ff[g] <= ri_s1_ff[g];
          ri_d_ff[g] <= ri_s2_ff[g];
        end
      end

      // Transmitter: a holding write wakes it before it can sleep
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_pd_ff[g] <= 1'b0;
        end else if (pce) begin
          if (!en || transmit_holding_wr[g]) begin
            tx_pd_ff[g] <= 1'b0;
          end else if (tx_holding_empty[g] && tx_shift_empty[g]) begin
            tx_pd_ff[g] <= 1'b1;
          end
        end
      end

      // Receiver: a line edge wakes it so the start bit is caught
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_pd_ff[g] <= 1'b0;
        end else if (pce) begin
          if (!en || rxd_s2_ff[g] != rxd_d_ff[g]) begin
            rx_pd_ff[g] <= 1'b0;
          end else if (rx_fifo_empty[g] && rx_wait_start[g]) begin
            rx_pd_ff[g] <= 1'b1;
          end
        end
      end

      // Ring change pulse runs regardless of the power state
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ri_chg_ff[g] <= 1'b0;
        end else if (pce) begin
          ri_chg_ff[g] <= ri_s2_ff[g] != ri_d_ff[g];
        end
      end
    end
  endgenerate

  assign tx_powered_down = tx_pd_ff;
  assign rx_powered_down = rx_pd_ff;
  assign ring_change = ri_chg_ff;

  // ==========================================================
  // Parallel port: recomputed every cycle from mode and config
  logic epp_pd_ff;
  logic ecp_pd_ff;
  logic par_en;
  logic ecr_legacy;
  assign par_en = auto_ff[AUTO_PAR] || direct_ff[AUTO_PAR];
  assign ecr_legacy = ecr_mode == ECR_SPP || ecr_mode == ECR_BIDIR
    || ecr_mode == ECR_EPP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epp_pd_ff <= 1'b0;
      ecp_pd_ff <= 1'b0;
    end else if (pce) begin
      epp_pd_ff <= par_en && (!par_ff[PAR_EPP]
        || (par_ff[PAR_ECP] && ecr_mode != ECR_EPP));
      ecp_pd_ff <= par_en && (!par_ff[PAR_ECP]
        || ecr_legacy);
    end
  end
  assign epp_powered_down = epp_pd_ff;
  assign ecp_powered_down = ecp_pd_ff;

  // ==========================================================
  // Read mux; bus logic never sleeps so wake accesses are seen
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      IDX_STAT_A: rd_byte = fdc_status_a;
      IDX_STAT_B: rd_byte = fdc_status_b;
      IDX_DOC: rd_byte = doc_ff;
      IDX_MSR_RATE: rd_byte = fdc_main_status;
      IDX_FIFO: rd_byte = fdc_fifo_rdata;
      IDX_DIR_CCR: rd_byte = fdc_drive_input;
      IDX_DIRECT: rd_byte = direct_ff;
      IDX_AUTO: rd_byte = auto_ff;
      IDX_PSTAT: rd_byte = {ecp_pd_ff, epp_pd_ff, rx_pd_ff,
        tx_pd_ff, rate_pd_ff, fdc_pd};
      IDX_PAR: rd_byte = par_ff;
      default: rd_byte = 8'h00;
    endcase
  end
  assign prdata = {24'h000000, rd_byte};
endmodule : apd_ctrl

// file: design/apd_idle_timer.sv
/*
  Idle interval timer for floppy auto powerdown.
  Assumes restart and run come from logic on the same clock.
*/
`timescale 1ns/1ns
module apd_idle_timer #(
  parameter int TERM = apd_pkg::IDLE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // Control
  input wire logic run,
  input wire logic restart,
  // Status
  output logic expired
);
  import apd_pkg::*;

  localparam logic [TMR_W-1:0] LAST = TMR_W'(TERM - 1);

  logic [TMR_W-1:0] cnt_ff;
  logic done_ff;

  // Counter stops at the terminal count; disabling clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (pce) begin
      if (!run || restart) begin
        cnt_ff <= '0;
        done_ff <= 1'b0;
      end else if (cnt_ff == LAST) begin
        done_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign expired = done_ff;
endmodule : apd_idle_timer

// file: sim/apd_ctrl_chk.sv
/*
  Checker for apd_ctrl: bus refusal, drive pins, wake and entry timing.
  Assumes it is bound to apd_ctrl and that all logic runs on pclk.
*/
`timescale 1ns/1ns
module apd_ctrl_chk #(
  parameter int IDLE_CYCLES = 20
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Floppy side
  input wire logic fdc_reset,
  input wire logic fdc_fifo_rd,
  input wire logic fdc_powered_down,
  input wire logic [3:0] motor_on_oe,
  input wire logic write_stream_oe,
  input wire logic write_gate_oe,
  input wire logic step_pulse_core,
  input wire logic step_pulse_out,
  // Serial side
  input wire logic [1:0] tx_holding_empty,
  input wire logic [1:0] tx_shift_empty,
  input wire logic [1:0] transmit_holding_wr,
  input wire logic [1:0] serial_receive_in,
  input wire logic [1:0] ring_indicator_in,
  input wire logic [1:0] tx_powered_down,
  input wire logic [1:0] rx_powered_down,
  input wire logic [1:0] ring_change
);
  // ==========================================================
  // Address decode, kept apart from the design's own decode
  logic [5:0] idx;
  logic mapped;
  logic acc;
  assign idx = {2'b00, paddr[5:2]}; // Upper address bits alias
  assign mapped = (paddr[1:0] == 2'h0) && (idx inside {6'h0, 6'h1, 6'h2,
    6'h4, 6'h5, 6'h7, 6'h8, 6'h9, 6'ha, 6'hb});
  assign acc = psel && penable && pce;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  property p_slverr;
    pslverr == (psel && penable && !mapped);
  endproperty
  a_slverr: assert property (p_slverr) else $error("slverr wrong");
  property p_fdd_pins;
    {motor_on_oe, write_stream_oe, write_gate_oe} == {6{!fdc_powered_down}}
      && step_pulse_out == step_pulse_core;
  endproperty
  a_fdd_pins: assert property (p_fdd_pins) else $error("pin state");
  property p_fifo_rd;
    acc && !pwrite && paddr == 8'h14 |-> fdc_fifo_rd;
  endproperty
  a_fifo_rd: assert property (p_fifo_rd) else $error("no fifo rd");
  property p_swreset;
    acc && pwrite && ((paddr == 8'h10 && pwdata[7]) ||
      (paddr == 8'h08 && !pwdata[2])) |=> fdc_reset;
  endproperty
  a_swreset: assert property (p_swreset) else $error("no reset");
  property p_rate_pd;
    acc && pwrite && paddr == 8'h10 && pwdata[6] && !pwdata[7]
      |=> fdc_powered_down;
  endproperty
  a_rate_pd: assert property (p_rate_pd) else $error("rate pd");
  property p_tx_entry;
    $rose(tx_powered_down[0])
      |-> $past(tx_holding_empty[0]) && $past(tx_shift_empty[0]);
  endproperty
  a_tx_entry: assert property (p_tx_entry) else $error("tx entry");
  property p_tx_wake;
    transmit_holding_wr[0] && pce |=> !tx_powered_down[0];
  endproperty
  a_tx_wake: assert property (p_tx_wake) else $error("tx wake");
  property p_rx_wake;
    $changed(serial_receive_in[0]) && rx_powered_down[0]
      |-> ##[1:5] !rx_powered_down[0];
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("rx wake");
  property p_ring;
    $changed(ring_indicator_in[0]) |-> ##[2:6] ring_change[0];
  endproperty
  a_ring: assert property (p_ring) else $error("ring lost");
endmodule : apd_ctrl_chk

bind apd_ctrl apd_ctrl_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .fdc_reset(fdc_reset), .fdc_fifo_rd(fdc_fifo_rd),
  .fdc_powered_down(fdc_powered_down), .motor_on_oe(motor_on_oe),
  .write_stream_oe(write_stream_oe), .write_gate_oe(write_gate_oe),
  .step_pulse_core(step_pulse_core), .step_pulse_out(step_pulse_out),
  .tx_holding_empty(tx_holding_empty), .tx_shift_empty(tx_shift_empty),
  .transmit_holding_wr(transmit_holding_wr),
  .serial_receive_in(serial_receive_in),
  .ring_indicator_in(ring_indicator_in),
  .tx_powered_down(tx_powered_down), .rx_powered_down(rx_powered_down),
  .ring_change(ring_change));

// file: sim/tb.sv
/*
  Self-checking bench for apd_ctrl: registers over APB, floppy auto
  and rate powerdown, serial and parallel powerdown.
  Assumes a short idle count so the floppy timer expires quickly.
*/
`timescale 1ns/1ns
module tb;
  import apd_pkg::*;
  localparam int IDLE = 20;
  // ==========================================================
  // Signals
  logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, msr_in;
  logic [31:0] pwdata, prdata, rdata;
  logic fdc_int, huld, fdc_pd, epp_pd, ecp_pd, fdc_rst, ws_oe, wg_oe;
  logic [6:0] pat;
  logic act, dso;
  logic [3:0] mot_oe;
  logic [2:0] ecr;
  logic [1:0] txh_e, txs_e, tx_wr, rxf_e, rx_ws, rxd, ri, tx_pd, rx_pd, rc;
  int fail_count, total_checks;
  // ==========================================================
  // Device under test; status bytes fixed so reads can be judged
  apd_ctrl #(.IDLE_CYCLES(IDLE)) i_dut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fdc_status_a(8'h5a), .fdc_status_b(8'ha5), .fdc_main_status(msr_in),
    .fdc_fifo_rdata(8'h3c), .fdc_drive_input(8'hc3), .fdc_int(fdc_int),
    .head_unload_done(huld), .fdc_reset(fdc_rst), .fdc_fifo_wr(),
    .fdc_fifo_rd(), .fdc_fifo_wdata(), .fdc_rate_cfg(), .fdc_active(act),
    .write_stream_core(pat[0]), .write_gate_core(pat[1]),
    .step_direction_core(pat[2]), .step_pulse_core(pat[3]),
    .head_select_core(pat[4]), .density_select_core(pat[6:5]),
    .motor_on_out(), .motor_on_oe(mot_oe), .drive_select_out(),
    .drive_select_oe(dso), .write_stream_out(), .write_stream_oe(ws_oe),
    .write_gate_out(), .write_gate_oe(wg_oe), .step_direction_out(),
    .step_pulse_out(), .head_select_out(), .density_select_out(),
    .tx_holding_empty(txh_e), .tx_shift_empty(txs_e),
    .transmit_holding_wr(tx_wr), .rx_fifo_empty(rxf_e),
    .rx_wait_start(rx_ws), .serial_receive_in(rxd),
    .ring_indicator_in(ri), .tx_powered_down(tx_pd),
    .rx_powered_down(rx_pd), .ring_change(rc), .ecr_mode(ecr),
    .epp_powered_down(epp_pd), .ecp_powered_down(ecp_pd),
    .fdc_powered_down(fdc_pd));
  // Clock, and a moving pattern on the drive pins from the core
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    pat <= pat + 7'h01;
  end
  // ==========================================================
  // Shared tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      fail_count++;
      final_report();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  // Bounded wait for the floppy power state; a miss ends the run
  task automatic wait_fdc(input logic exp, input int n);
    for (int i = 0; i < n && fdc_pd !== exp; i++) begin
      @(posedge pclk);
    end
    chk(fdc_pd, exp);
    if (fdc_pd !== exp) begin
      final_report();
    end
  endtask : wait_fdc
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(8'h08, {24'h0, DOC_RST});
    rd(8'h24, {24'h0, CFG_RST});
    rd(8'h00, 32'h5a);
    rd(8'h1c, 32'hc3);
    xfer(1'b1, 8'h0c, 32'hff);
    chk(rerr, 1'b1);
    pce <= 1'b0;
    xfer(1'b1, 8'h20, 32'h01);
    pce <= 1'b1;
    rd(8'h20, 32'h0);
    xfer(1'b1, 8'h20, 32'h01);
    cyc(1);
    chk(fdc_pd, 1'b1);
    xfer(1'b1, 8'h20, 32'h0);
  endtask : t_regs
  task automatic t_fdc;
    xfer(1'b1, 8'h24, 32'h01);
    cyc(IDLE / 2);
    chk(fdc_pd, 1'b0);
    wait_fdc(1'b1, IDLE / 2 + 8);
    chk({mot_oe, ws_oe, wg_oe, dso}, 7'h0);
    chk(act, 1'b0);
    rd(8'h00, 32'h5a);
    xfer(1'b1, 8'h08, 32'h0c);
    rd(8'h08, 32'h0c);
    cyc(1);
    chk(fdc_pd, 1'b1);
    rd(8'h10, {24'h0, MSR_IDLE});
    cyc(1);
    chk(fdc_pd, 1'b0);
    cyc(IDLE / 2);
    chk(fdc_pd, 1'b0);
    wait_fdc(1'b1, IDLE);
    rd(8'h14, 32'h3c);
    cyc(1);
    chk(fdc_pd, 1'b0);
    wait_fdc(1'b1, IDLE + 8);
    xfer(1'b1, 8'h14, 32'h55);
    cyc(1);
    chk(fdc_pd, 1'b0);
    wait_fdc(1'b1, IDLE + 8);
    xfer(1'b1, 8'h08, 32'h1c);
    cyc(1);
    chk(fdc_pd, 1'b0);
    cyc(IDLE + 8);
    rd(8'h08, 32'h1c);
    chk(fdc_pd, 1'b0);
    fdc_int <= 1'b1;
    xfer(1'b1, 8'h08, 32'h0c);
    cyc(IDLE + 8);
    chk(fdc_pd, 1'b0);
    fdc_int <= 1'b0;
    msr_in <= 8'h90;
    cyc(IDLE + 8);
    chk(fdc_pd, 1'b0);
    msr_in <= MSR_IDLE;
    wait_fdc(1'b1, IDLE + 8);
    xfer(1'b1, 8'h24, 32'h00);
    cyc(2);
    chk(fdc_pd, 1'b0);
    cyc(IDLE + 8);
    chk(fdc_pd, 1'b0);
    xfer(1'b1, 8'h24, 32'h01);
    cyc(IDLE / 2);
    chk(fdc_pd, 1'b0);
    wait_fdc(1'b1, IDLE);
  endtask : t_fdc
  // Rate powerdown on top of auto powerdown, then both reset paths
  task automatic t_rate;
    xfer(1'b1, 8'h10, 32'h40);
    cyc(1);
    rd(8'h28, 32'h03);
    rd(8'h10, {24'h0, MSR_IDLE});
    cyc(1);
    chk(fdc_pd, 1'b1);
    xfer(1'b1, 8'h10, 32'h80);
    cyc(1);
    chk({fdc_rst, fdc_pd}, 2'b10);
    wait_fdc(1'b1, IDLE + 8);
    xfer(1'b1, 8'h08, 32'h00);
    cyc(1);
    chk({fdc_rst, fdc_pd}, 2'b10);
    xfer(1'b1, 8'h08, 32'h04);
    xfer(1'b1, 8'h24, 32'h00);
  endtask : t_rate
  task automatic t_serial;
    logic s_rx, s_ri;
    txh_e <= 2'b11;
    txs_e <= 2'b01;
    rx_ws <= 2'b01;
    cyc(3);
    chk({rx_pd, tx_pd}, 4'h0);
    xfer(1'b1, 8'h24, 32'h30);
    cyc(3);
    chk({rx_pd, tx_pd}, 4'b0101);
    tx_wr <= 2'b01;
    cyc(1);
    tx_wr <= 2'b00;
    cyc(1);
    chk(tx_pd[0], 1'b0);
    rxd <= 2'b10;
    ri <= 2'b01;
    s_rx = 1'b0;
    s_ri = 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge pclk);
      s_rx |= (rx_pd[0] === 1'b0);
      s_ri |= (rc[0] === 1'b1);
    end
    chk({s_rx, s_ri}, 2'b11);
    xfer(1'b1, 8'h24, 32'h00);
  endtask : t_serial
  task automatic t_par;
    logic [2:0] m [4] = '{ECR_SPP, ECR_BIDIR, 3'h3, ECR_EPP};
    xfer(1'b1, 8'h2c, 32'h03);
    xfer(1'b1, 8'h24, 32'h08);
    for (int i = 0; i < 4; i++) begin
      ecr <= m[i];
      cyc(3);
      chk({epp_pd, ecp_pd}, {m[i] != ECR_EPP, m[i] != 3'h3});
    end
    xfer(1'b1, 8'h2c, 32'h00);
    cyc(3);
    chk({epp_pd, ecp_pd}, 2'b11);
    xfer(1'b1, 8'h24, 32'h00);
    cyc(3);
    chk({epp_pd, ecp_pd}, 2'b00);
  endtask : t_par
  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, fdc_int, pat, ecr} = '0;
    {pce, huld, paddr, pwdata, msr_in} = {2'b11, 40'h0, MSR_IDLE};
    {txh_e, txs_e, tx_wr, rxf_e, rx_ws, rxd, ri} = 14'h0cc;
    fail_count = 0;
    total_checks = 0;
    cyc(4);
    presetn <= 1'b1;
    t_regs();
    t_fdc();
    t_rate();
    t_serial();
    t_par();
    final_report();
  end
endmodule : tb
